//--- hw/pcrm_pkg.sv
// Constants, register map and state types of the power, clock-rate and reset manager.
package pcrm_pkg;

  // Register offsets.
  localparam logic [3:0] OFS_PMR   = 4'h0;
  localparam logic [3:0] OFS_POWER_CONTROL_REGISTER  = 4'h1;
  localparam logic [3:0] OFS_AUX   = 4'h2;
  localparam logic [3:0] OFS_WDCTL = 4'h3;

  // Field positions.
  localparam int PMR_SEL_LO = 6;
  localparam int PMR_SEL_HI = 7;
  localparam int PMR_SWB_EN = 5;
  localparam int POWER_CONTROL_REGISTER_PDOWN = 1;
  localparam int AUX_SWRST  = 3;
  localparam int WD_RUN     = 7;
  localparam int WD_PWRON   = 6;
  localparam int WD_TSEL_LO = 4;
  localparam int WD_IRQF    = 3;
  localparam int WD_RSTF    = 2;
  localparam int WD_RSTEN   = 1;
  localparam int WD_CLEAR   = 0;

  // Clock-rate selections and clocks per machine cycle.
  localparam logic [1:0] SEL_FAST = 2'b00;
  localparam logic [1:0] SEL_MID  = 2'b10;
  localparam logic [1:0] SEL_SLOW = 2'b11;
  localparam int         DIV_FAST = 4;
  localparam int         DIV_MID  = 64;
  localparam int         DIV_SLOW = 1024;

  // Cycle counts.
  localparam int         WDT_DELAY_CLK = 512;
  localparam logic [1:0] RST_HOLD_MC   = 2'd2;
  localparam logic [1:0] EXT_QUAL_MC   = 2'd2;

  // Values after reset.
  localparam logic [15:0] RESET_PC = 16'h0000;
  localparam logic [7:0]  RESET_SP = 8'h07;

  // Operating mode, one-hot.
  typedef enum logic [2:0] {
    MODE_RUN   = 3'b001,
    MODE_PDREQ = 3'b010,
    MODE_PD    = 3'b100
  } pcrm_mode_type;

  // Whole state of the block.
  typedef struct packed {
    logic [2:0]    ext_s;
    logic [2:0]    bo_s;
    logic [2:0]    rxd_s;
    logic [2:0]    ei0_s;
    logic [2:0]    ei1_s;
    logic          ext_f;
    logic          bo_f;
    logic          rxd_f;
    logic [1:0]    ei_f;
    pcrm_mode_type mode;
    logic [9:0]    pcnt;
    logic          mce;
    logic [1:0]    div_sel;
    logic [1:0]    pend_sel;
    logic          pend_valid;
    logic          pend_age;
    logic          switchback_enable;
    logic [1:0]    ext_hi;
    logic [1:0]    rst_mc;
    logic          core_rst;
    logic          wd_arm;
    logic [9:0]    wd_cnt;
    logic          wd_run;
    logic          wd_pwron;
    logic [1:0]    wd_tsel;
    logic          wd_if;
    logic          wd_rf;
    logic          wd_rsten;
    logic          ale;
    logic          program_store_strobe;
    logic [15:0]   pc_init;
    logic [7:0]    sp_init;
    logic [7:0]    rdata;
  } pcrm_state_type;

endpackage : pcrm_pkg

//--- hw/pcrm_top.sv
// Power, clock-rate and reset manager of the microcontroller core.
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Machine cycle is 4 clocks by default, 64 or 1024 in economy mode.
// - High select 0 gives 4; high 1 with low 0 gives 64, with low 1 gives 1024.
// - A new rate applies only after one full machine cycle since the write.
// - Peripherals run on the same machine-cycle enable as the core; the watchdog grace delay counts clocks.
// - With switchback on, serial, I2C or external interrupt events force divide-by-4.
// - Receive start-bit fall or transmit buffer write triggers switchback.
// - An I2C start condition triggers switchback.
// - Rate writes are ignored while switchback is on and serial traffic runs.
// - Every reset source forces divide-by-4.
// - Power-down bit write halts all clocks after the current instruction.
// - In power-down the latch and program strobes are low, ports hold.
// - External reset pin high ends power-down and restarts at address zero.
// - Wake sources: external, keyboard, brownout, watchdog interrupt when internally clocked.
// - External pin wakes only when enabled, globally enabled and level-sensitive.
// - Reset pin sampled each machine cycle; two highs assert, release two cycles late.
// - Power-on reset sets the power-on flag; software should clear it.
// - Watchdog timeout sets its flag; 512 clocks later reset two machine cycles.
// - Timed-access write of the auxiliary reset bit resets the whole system.
// - Reset loads program counter zero, stack pointer 07h; power-on stops watchdog.
// - Watchdog control reset value depends on the reset source.
// - Watchdog control bits 7 to 1 readable, clear bit reads zero; protected bits need timed access to write.
module pcrm_top (
  // Clock and reset.
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_N_I,
  // Register port.
  input  wire logic [3:0]  ADDR_I,
  input  wire logic [7:0]  WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [7:0]  RDATA_O,
  input  wire logic        TIMED_OK_I,
  // Reset sources.
  input  wire logic        EXT_RST_I,
  input  wire logic        BROWNOUT_I,
  // Switchback sources.
  input  wire logic        UART_RXD_I,
  input  wire logic        UART_RX_EN_I,
  input  wire logic        UART_TX_WR_I,
  input  wire logic        UART_BUSY_I,
  input  wire logic        I2C_START_I,
  input  wire logic        I2C_BUSY_I,
  input  wire logic        EXT_INT_ACK_I,
  // Wake sources.
  input  wire logic [1:0]  EXT_INT_N_I,
  input  wire logic [1:0]  EXT_INT_EN_I,
  input  wire logic [1:0]  EXT_INT_LEVEL_I,
  input  wire logic        GLOBAL_INT_EN_I,
  input  wire logic        KBD_INT_I,
  input  wire logic        WDT_TIMEOUT_I,
  input  wire logic        WDT_CLK_SEL_I,
  // Core strobes.
  input  wire logic        ADDR_LATCH_I,
  input  wire logic        PROG_STROBE_I,
  // Outputs to core and peripherals.
  output logic             MCYCLE_EN_O,
  output logic             CORE_RST_O,
  output logic             POWER_DOWN_O,
  output logic             ADDR_LATCH_O,
  output logic             PROG_STROBE_O,
  output logic             WDT_RUN_O,
  output logic      [1:0]  WDT_TSEL_O,
  output logic             WDT_IRQ_O,
  output logic      [15:0] RST_PC_O,
  output logic      [7:0]  RST_SP_O
);

  localparam logic [9:0] LIM_FAST = 10'(pcrm_pkg::DIV_FAST - 1);
  localparam logic [9:0] LIM_MID  = 10'(pcrm_pkg::DIV_MID - 1);
  localparam logic [9:0] LIM_SLOW = 10'(pcrm_pkg::DIV_SLOW - 1);
  localparam logic [9:0] WD_LOAD  = 10'(pcrm_pkg::WDT_DELAY_CLK - 1);

  pcrm_pkg::pcrm_state_type st;
  pcrm_pkg::pcrm_state_type nx;
  logic       swb_evt;
  logic       ser_busy;
  logic       wake;
  logic       wd_fire;
  logic       sw_rst;
  logic       wr_pmr;
  logic       wr_wd;
  logic [9:0] lim;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  always_comb
  begin
    nx = st;
    // Three-stage pin synchronisers; a change counts once stages two and three agree.
    nx.ext_s = {st.ext_s[1:0], EXT_RST_I};
    nx.bo_s  = {st.bo_s[1:0], BROWNOUT_I};
    nx.rxd_s = {st.rxd_s[1:0], UART_RXD_I};
    nx.ei0_s = {st.ei0_s[1:0], EXT_INT_N_I[0]};
    nx.ei1_s = {st.ei1_s[1:0], EXT_INT_N_I[1]};
    if (st.ext_s[1] == st.ext_s[2])
      nx.ext_f = st.ext_s[2];
    if (st.bo_s[1] == st.bo_s[2])
      nx.bo_f = st.bo_s[2];
    if (st.rxd_s[1] == st.rxd_s[2])
      nx.rxd_f = st.rxd_s[2];
    if (st.ei0_s[1] == st.ei0_s[2])
      nx.ei_f[0] = st.ei0_s[2];
    if (st.ei1_s[1] == st.ei1_s[2])
      nx.ei_f[1] = st.ei1_s[2];

    wr_pmr   = WR_I && !st.core_rst && (ADDR_I == pcrm_pkg::OFS_PMR);
    wr_wd    = WR_I && !st.core_rst && (ADDR_I == pcrm_pkg::OFS_WDCTL);
    ser_busy = st.switchback_enable && (UART_BUSY_I || I2C_BUSY_I);
    swb_evt  = st.switchback_enable && ((UART_RX_EN_I && st.rxd_f && !nx.rxd_f) || UART_TX_WR_I
               || I2C_START_I || EXT_INT_ACK_I);
    wake = (GLOBAL_INT_EN_I && |(EXT_INT_EN_I & EXT_INT_LEVEL_I & ~st.ei_f))
           || KBD_INT_I || (WDT_TIMEOUT_I && !WDT_CLK_SEL_I);

    case (st.div_sel)
      pcrm_pkg::SEL_MID:  lim = LIM_MID;
      pcrm_pkg::SEL_SLOW: lim = LIM_SLOW;
      default:            lim = LIM_FAST;
    endcase

    // Shared enable for core and peripherals.
    nx.mce = 1'b0;
    if (!st.mode[2])
    begin
      if (st.pcnt >= lim)
      begin
        nx.pcnt = 10'h000;
        nx.mce  = 1'b1;
      end
      else
        nx.pcnt = st.pcnt + 10'h001;
    end

    // Apply the pending rate one machine cycle late.
    if (nx.mce && st.pend_valid)
    begin
      if (st.pend_age)
      begin
        nx.div_sel    = st.pend_sel;
        nx.pend_valid = 1'b0;
      end
      else
        nx.pend_age = 1'b1;
    end
    if (wr_pmr)
    begin
      nx.switchback_enable = WDATA_I[pcrm_pkg::PMR_SWB_EN];
      if (!ser_busy)
      begin
        nx.pend_sel   = {WDATA_I[pcrm_pkg::PMR_SEL_HI], WDATA_I[pcrm_pkg::PMR_SEL_LO]};
        nx.pend_valid = 1'b1;
        nx.pend_age   = 1'b0;
      end
    end
    if (swb_evt)
    begin
      nx.div_sel    = pcrm_pkg::SEL_FAST;
      nx.pend_valid = 1'b0;
    end
    // Power-down entry at the end of the instruction.
    // Reset pin or brownout ends power-down.
    case (st.mode)
      pcrm_pkg::MODE_RUN:
        if (WR_I && !st.core_rst && (ADDR_I == pcrm_pkg::OFS_POWER_CONTROL_REGISTER)
            && WDATA_I[pcrm_pkg::POWER_CONTROL_REGISTER_PDOWN])
          nx.mode = pcrm_pkg::MODE_PDREQ;
      pcrm_pkg::MODE_PDREQ:
        if (st.mce) // Enter after the closing pulse, so no pulse shows in power-down.
          nx.mode = pcrm_pkg::MODE_PD;
      pcrm_pkg::MODE_PD:
        if (wake || st.ext_f || st.bo_f)
          nx.mode = pcrm_pkg::MODE_RUN;
      default:
        nx.mode = pcrm_pkg::MODE_RUN;
    endcase

    // Free bits writable, protected bits need timed access.
    if (wr_wd)
    begin
      nx.wd_tsel = WDATA_I[pcrm_pkg::WD_TSEL_LO +: 2];
      nx.wd_rf   = WDATA_I[pcrm_pkg::WD_RSTF];
      if (TIMED_OK_I)
      begin
        nx.wd_run   = WDATA_I[pcrm_pkg::WD_RUN];
        nx.wd_pwron = WDATA_I[pcrm_pkg::WD_PWRON];
        nx.wd_rsten = WDATA_I[pcrm_pkg::WD_RSTEN];
        nx.wd_if    = WDATA_I[pcrm_pkg::WD_IRQF];
        if (WDATA_I[pcrm_pkg::WD_CLEAR])
          nx.wd_arm = 1'b0;
      end
    end

    // Timeout flag, then reset after the grace delay unless cleared.
    wd_fire = 1'b0;
    if (st.wd_arm && !st.mode[2] && nx.wd_arm)
    begin
      if (st.wd_cnt == 10'h000)
      begin
        nx.wd_arm = 1'b0;
        wd_fire   = 1'b1;
      end
      else
        nx.wd_cnt = st.wd_cnt - 10'h001;
    end
    if (WDT_TIMEOUT_I)
    begin
      nx.wd_if = 1'b1;
      if (st.wd_rsten && !st.wd_arm)
      begin
        nx.wd_arm = 1'b1;
        nx.wd_cnt = WD_LOAD;
      end
    end
    sw_rst = WR_I && !st.core_rst && TIMED_OK_I && (ADDR_I == pcrm_pkg::OFS_AUX)
             && WDATA_I[pcrm_pkg::AUX_SWRST];
    // Reset pin sampled once per machine cycle.
    if (st.mce)
    begin
      if (!st.ext_f)
        nx.ext_hi = 2'd0;
      else if (st.ext_hi != pcrm_pkg::EXT_QUAL_MC)
        nx.ext_hi = st.ext_hi + 2'd1;
    end
    // A fresh reset starts mid machine cycle; one extra pulse keeps two whole cycles.
    if ((st.ext_hi == pcrm_pkg::EXT_QUAL_MC) || st.bo_f || wd_fire || sw_rst)
      nx.rst_mc = (st.rst_mc == 2'd0) ? 2'(pcrm_pkg::RST_HOLD_MC + 2'd1)
                                      : pcrm_pkg::RST_HOLD_MC;
    else if (st.mce && (st.rst_mc != 2'd0))
      nx.rst_mc = st.rst_mc - 2'd1;
    nx.core_rst = (nx.rst_mc != 2'd0);
    // Watchdog reset sets its cause flag.
    if (wd_fire)
      nx.wd_rf = 1'b1;
    // Every reset forces the fast rate.
    if (nx.core_rst)
    begin
      nx.div_sel    = pcrm_pkg::SEL_FAST;
      nx.pend_valid = 1'b0;
      nx.switchback_enable        = 1'b0;
      nx.mode       = pcrm_pkg::MODE_RUN;
      nx.wd_run     = 1'b0;
      nx.wd_if      = 1'b0;
      nx.wd_rsten   = 1'b0;
      nx.wd_arm     = 1'b0;
      nx.pc_init    = pcrm_pkg::RESET_PC;
      nx.sp_init    = pcrm_pkg::RESET_SP;
    end

    nx.ale  = ADDR_LATCH_I && !nx.mode[2];
    nx.program_store_strobe = PROG_STROBE_I && !nx.mode[2];

    // Read data stand one cycle after the strobe; unmapped reads give zero.
    nx.rdata = 8'h00;
    if (RD_I)
    begin
      case (ADDR_I)
        pcrm_pkg::OFS_PMR:   nx.rdata = {st.div_sel, st.switchback_enable, 5'h00};
        pcrm_pkg::OFS_POWER_CONTROL_REGISTER:  nx.rdata = {6'h00, !st.mode[0], 1'b0};
        pcrm_pkg::OFS_WDCTL: nx.rdata = {st.wd_run, st.wd_pwron, st.wd_tsel, st.wd_if,
                                         st.wd_rf, st.wd_rsten, 1'b0};
        default:             nx.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register; power-on reset.
  always_ff @(posedge CLK_SYS_I)
  begin
    if (!RST_N_I)
    begin
      st          <= '0;
      st.mode     <= pcrm_pkg::MODE_RUN;
      st.rst_mc   <= pcrm_pkg::RST_HOLD_MC;
      st.core_rst <= 1'b1;
      st.wd_pwron <= 1'b1;
      st.pc_init  <= pcrm_pkg::RESET_PC;
      st.sp_init  <= pcrm_pkg::RESET_SP;
    end
    else
      st <= nx;
  end

  // Outputs straight from the state register.
  assign RDATA_O       = st.rdata;
  assign MCYCLE_EN_O   = st.mce;
  assign CORE_RST_O    = st.core_rst;
  assign POWER_DOWN_O  = st.mode[2];
  assign ADDR_LATCH_O  = st.ale;
  assign PROG_STROBE_O = st.program_store_strobe;
  assign WDT_RUN_O     = st.wd_run;
  assign WDT_TSEL_O    = st.wd_tsel;
  assign WDT_IRQ_O     = st.wd_if;
  assign RST_PC_O      = st.pc_init;
  assign RST_SP_O      = st.sp_init;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_N_I);

  property p_fast_period;
    st.mce && st.div_sel == pcrm_pkg::SEL_FAST && !st.pend_valid && st.mode[0]
      |=> !st.mce [*3] ##1 st.mce;
  endproperty
  a_fast_period: assert property (p_fast_period) else $error("fast rate period wrong");
  property p_rate_delay;
    wr_pmr && !st.pend_valid && !swb_evt && !nx.core_rst
      |=> st.div_sel == $past(st.div_sel);
  endproperty
  a_rate_delay: assert property (p_rate_delay) else $error("rate applied too early");
  property p_switchback;
    swb_evt |=> st.div_sel == pcrm_pkg::SEL_FAST && !st.pend_valid;
  endproperty
  a_switchback: assert property (p_switchback) else $error("switchback missed");
  property p_busy_block;
    wr_pmr && ser_busy && !nx.core_rst |=> $stable(st.pend_sel);
  endproperty
  a_busy_block: assert property (p_busy_block) else $error("rate write not blocked");
  property p_reset_fast;
    st.core_rst |-> st.div_sel == pcrm_pkg::SEL_FAST && !st.switchback_enable;
  endproperty
  a_reset_fast: assert property (p_reset_fast) else $error("reset left slow rate");
  property p_pd_strobes;
    st.mode[2] |-> !ADDR_LATCH_O && !PROG_STROBE_O && !MCYCLE_EN_O;
  endproperty
  a_pd_strobes: assert property (p_pd_strobes) else $error("strobes active in power-down");
  property p_ext_wake;
    st.mode[2] && !st.core_rst && GLOBAL_INT_EN_I
      && |(EXT_INT_EN_I & EXT_INT_LEVEL_I & ~st.ei_f) |=> !st.mode[2];
  endproperty
  a_ext_wake: assert property (p_ext_wake) else $error("level wake ignored");
  property p_ext_reset;
    st.ext_hi == pcrm_pkg::EXT_QUAL_MC |=> st.core_rst;
  endproperty
  a_ext_reset: assert property (p_ext_reset) else $error("qualified pin did not reset");
  property p_wd_reset;
    st.wd_arm && st.wd_cnt == 10'h000 && !st.mode[2] && !wr_wd |=> st.core_rst && st.wd_rf;
  endproperty
  a_wd_reset: assert property (p_wd_reset) else $error("watchdog reset missing");
  property p_protect;
    wr_wd && !TIMED_OK_I && !nx.core_rst |=> $stable(st.wd_rsten) && $stable(st.wd_run);
  endproperty
  a_protect: assert property (p_protect) else $error("protected bit written");
  c_slow: cover property (st.mce && st.div_sel == pcrm_pkg::SEL_SLOW);
  c_pdown: cover property (st.mode[1] ##1 st.mode[2]);
  c_swb: cover property (swb_evt && st.div_sel != pcrm_pkg::SEL_FAST);
  c_wdrst: cover property (wd_fire);

endmodule : pcrm_top

//--- bench/test_pcrm_top.sv
// Self-checking testbench of the power, clock-rate and reset manager.
`timescale 1ns/1ps

module test_pcrm_top;
  logic        clk, rst_n, wr, rd, tok, ext_rst, bo, rxd, rx_en, tx_wr, u_busy;
  logic        i2c_st, i2c_busy, ei_ack, gie, kbd, wdt_to, wdt_sel, ale_i, program_store_strobe_i;
  logic        mce, core_rst, pdown, ale_o, program_store_strobe_o, wd_run, wd_irq;
  logic [3:0]  addr;
  logic [7:0]  wdata, rdata, rst_sp;
  logic [1:0]  ei_n, ei_en, ei_lvl, wd_tsel;
  logic [15:0] rst_pc;
  int          fail_count, check_count, n;

  // Device under test with every input driven by the bench.
  pcrm_top dut_u (
    .CLK_SYS_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .TIMED_OK_I(tok), .EXT_RST_I(ext_rst),
    .BROWNOUT_I(bo), .UART_RXD_I(rxd), .UART_RX_EN_I(rx_en), .UART_TX_WR_I(tx_wr),
    .UART_BUSY_I(u_busy), .I2C_START_I(i2c_st), .I2C_BUSY_I(i2c_busy),
    .EXT_INT_ACK_I(ei_ack), .EXT_INT_N_I(ei_n), .EXT_INT_EN_I(ei_en),
    .EXT_INT_LEVEL_I(ei_lvl), .GLOBAL_INT_EN_I(gie), .KBD_INT_I(kbd),
    .WDT_TIMEOUT_I(wdt_to), .WDT_CLK_SEL_I(wdt_sel), .ADDR_LATCH_I(ale_i),
    .PROG_STROBE_I(program_store_strobe_i), .MCYCLE_EN_O(mce), .CORE_RST_O(core_rst),
    .POWER_DOWN_O(pdown), .ADDR_LATCH_O(ale_o), .PROG_STROBE_O(program_store_strobe_o),
    .WDT_RUN_O(wd_run), .WDT_TSEL_O(wd_tsel), .WDT_IRQ_O(wd_irq),
    .RST_PC_O(rst_pc), .RST_SP_O(rst_sp)
  );

  // Free-running system clock of 10 ns.
  initial clk = 1'b0;
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops.
  task automatic conclude;
    $display("Checks %0d, errors %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // Compares one result and counts a mismatch.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One-cycle register write, optionally inside the timed-access window.
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic t);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    tok   <= t;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    tok   <= 1'b0;
  endtask : wr_reg

  // One-cycle register read; data is compared in the following cycle.
  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(16'(rdata), 16'(exp));
  endtask : rd_reg

  // Selects the watched output: 0 reset, 1 power-down, 2 machine-cycle enable.
  function automatic logic sig(input int k);
    return (k == 0) ? core_rst : (k == 1) ? pdown : mce;
  endfunction : sig

  // Bounded wait for a watched output; n holds the cycles spent.
  task automatic wait_for(input int k, input logic v, input int lim);
    n = 0;
    #1;
    while (sig(k) !== v)
    begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim)
      begin
        fail_count++;
        conclude();
      end
    end
  endtask : wait_for

  // Skips the switching pulses, then measures one machine cycle in clocks.
  task automatic per(input int exp);
    repeat (3)
    begin
      wait_for(2, 1'b1, 2100);
      @(posedge clk);
    end
    wait_for(2, 1'b1, 2100);
    chk(16'(n + 1), 16'(exp));
  endtask : per

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_n, wr, rd, tok, ext_rst, bo, rx_en, tx_wr, u_busy, i2c_st, i2c_busy} = '0;
    {ei_ack, gie, kbd, wdt_to, wdt_sel, ale_i, program_store_strobe_i} = '0;
    {addr, wdata, ei_en, ei_lvl} = '0;
    rxd = 1'b1;
    ei_n = 2'b11;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    ale_i <= 1'b1;
    program_store_strobe_i <= 1'b1;
    wait_for(0, 1'b0, 20);
    chk(rst_pc, 16'h0000);
    chk(16'(rst_sp), 16'h0007);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'h40);
    rd_reg(4'h7, 8'h00);
    per(4);
    wr_reg(pcrm_pkg::OFS_PMR, 8'h80, 1'b0);
    per(64);
    wr_reg(pcrm_pkg::OFS_PMR, 8'h40, 1'b0);
    per(4);
    wr_reg(pcrm_pkg::OFS_PMR, 8'hc0, 1'b0);
    per(1024);
    wr_reg(pcrm_pkg::OFS_PMR, 8'h00, 1'b0);
    per(4);
    rx_en <= 1'b1;
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(pcrm_pkg::OFS_PMR, 8'ha0, 1'b0);
      per(64);
      @(posedge clk);
      case (k)
        0: tx_wr <= 1'b1;
        1: i2c_st <= 1'b1;
        2: ei_ack <= 1'b1;
        default: rxd <= 1'b0;
      endcase
      @(posedge clk);
      {tx_wr, i2c_st, ei_ack} <= '0;
      repeat (8) @(posedge clk);
      rxd <= 1'b1;
      per(4);
    end
    rx_en <= 1'b0;
    // rate writes refused during serial traffic.
    wr_reg(pcrm_pkg::OFS_PMR, 8'ha0, 1'b0);
    per(64);
    u_busy <= 1'b1;
    wr_reg(pcrm_pkg::OFS_PMR, 8'h20, 1'b0);
    u_busy <= 1'b0;
    i2c_busy <= 1'b1;
    wr_reg(pcrm_pkg::OFS_PMR, 8'h20, 1'b0);
    i2c_busy <= 1'b0;
    per(64);
    rd_reg(pcrm_pkg::OFS_PMR, 8'ha0);
    // external reset qualification and rate recovery.
    wr_reg(pcrm_pkg::OFS_PMR, 8'h80, 1'b0);
    per(64);
    ext_rst <= 1'b1;
    wait_for(0, 1'b1, 400);
    chk(16'(n >= 64), 16'h0001);
    repeat (20) @(posedge clk);
    ext_rst <= 1'b0;
    wait_for(0, 1'b0, 300);
    chk(16'(n >= 8), 16'h0001);
    per(4);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'h40);
    // software reset needs the timed window.
    wr_reg(pcrm_pkg::OFS_PMR, 8'h80, 1'b0);
    wr_reg(pcrm_pkg::OFS_AUX, 8'h08, 1'b0);
    repeat (20) @(posedge clk);
    #1;
    chk(16'(core_rst), 16'h0000);
    wr_reg(pcrm_pkg::OFS_AUX, 8'h08, 1'b1);
    wait_for(0, 1'b1, 20);
    wait_for(0, 1'b0, 40);
    per(4);
    // protected and free watchdog control bits.
    wr_reg(pcrm_pkg::OFS_WDCTL, 8'hff, 1'b0);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'h74);
    wr_reg(pcrm_pkg::OFS_WDCTL, 8'hb0, 1'b1);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'hb0);
    chk(16'(wd_run), 16'h0001);
    chk(16'(wd_tsel), 16'h0003);
    wr_reg(pcrm_pkg::OFS_WDCTL, 8'h00, 1'b1);
    chk(16'({ale_o, program_store_strobe_o}), 16'h0003);
    ei_en <= 2'b01;
    gie <= 1'b1;
    wdt_sel <= 1'b1;
    wr_reg(pcrm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h02, 1'b0);
    wait_for(1, 1'b1, 20);
    chk(16'({ale_o, program_store_strobe_o}), 16'h0000);
    ei_n <= 2'b10;
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    repeat (20) @(posedge clk);
    #1;
    chk(16'(pdown), 16'h0001);
    rd_reg(pcrm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h02);
    ei_lvl <= 2'b01;
    wait_for(1, 1'b0, 10);
    ei_n <= 2'b11;
    wdt_sel <= 1'b0;
    // wake by keyboard, watchdog, brownout and reset pin.
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(pcrm_pkg::OFS_POWER_CONTROL_REGISTER, 8'h02, 1'b0);
      wait_for(1, 1'b1, 20);
      case (k)
        0: kbd <= 1'b1;
        1: wdt_to <= 1'b1;
        2: bo <= 1'b1;
        default: ext_rst <= 1'b1;
      endcase
      @(posedge clk);
      wdt_to <= 1'b0;
      wait_for(1, 1'b0, 10);
      repeat (30) @(posedge clk);
      #1;
      chk(16'(core_rst), 16'(k >= 2));
      {kbd, bo, ext_rst} <= '0;
      wait_for(0, 1'b0, 60);
    end
    chk(rst_pc, 16'h0000);
    // watchdog timeout, grace time and reset flag.
    wr_reg(pcrm_pkg::OFS_WDCTL, 8'h02, 1'b1);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'h02);
    @(posedge clk);
    wdt_to <= 1'b1;
    @(posedge clk);
    wdt_to <= 1'b0;
    @(posedge clk);
    #1;
    chk(16'(wd_irq), 16'h0001);
    wait_for(0, 1'b1, 600);
    chk(16'(n >= 500), 16'h0001);
    wait_for(0, 1'b0, 20);
    chk(16'(n >= 7), 16'h0001);
    rd_reg(pcrm_pkg::OFS_WDCTL, 8'h04);
    conclude();
  end
endmodule : test_pcrm_top
